// ==== acrb_pkg.sv ====
`default_nettype none
package acrb_pkg;
	// register offsets on the control port
	localparam logic [7:0] ADDR_ID        = 8'h00;
	localparam logic [7:0] ADDR_GLOBAL    = 8'h01;
	localparam logic [7:0] ADDR_OVF_FLAGS = 8'h02;
	localparam logic [7:0] ADDR_OVF_MASK  = 8'h03;
	localparam logic [7:0] ADDR_HPF       = 8'h04;
	localparam logic [7:0] ADDR_RSVD_A    = 8'h05;
	localparam logic [7:0] ADDR_PDN       = 8'h06;
	localparam logic [7:0] ADDR_RSVD_B    = 8'h07;
	localparam logic [7:0] ADDR_MUTE      = 8'h08;
	localparam logic [7:0] ADDR_RSVD_C    = 8'h09;
	localparam logic [7:0] ADDR_TRIS      = 8'h0A;

	// values after reset
	localparam logic [7:0] RST_GLOBAL    = 8'h00;
	localparam logic [7:0] RST_OVF_FLAGS = 8'hFF;
	localparam logic [7:0] RST_OVF_MASK  = 8'hFF;
	localparam logic [7:0] RST_HPF       = 8'h00;
	localparam logic [7:0] RST_PDN       = 8'h00;
	localparam logic [7:0] RST_MUTE      = 8'h00;
	localparam logic [7:0] RST_TRIS      = 8'h00;
	localparam logic [7:0] RST_RDATA     = 8'h00;
	localparam logic [3:0] RST_HALF_CNT  = 4'h0;

	// field positions
	localparam int GLB_PORT_EN_BIT = 7;
	localparam int GLB_RATIO_BIT   = 6;
	localparam int GLB_DIV_LSB     = 4;
	localparam int GLB_FMT_LSB   = 2;
	localparam int GLB_MODE_LSB  = 0;
	localparam int PDN_REF_BIT   = 5;
	localparam int OSCILLATOR_SHUTDOWN_BIT   = 4;
	localparam int PDN_PAIR_LSB  = 0;

	// writable bits; the rest are reserved and read as zero
	localparam logic [7:0] PDN_WRITE_MASK  = 8'h3F;
	localparam logic [7:0] TRIS_WRITE_MASK = 8'h0F;

	// crystal division counted in half periods of the crystal input
	localparam logic [3:0] DIV_HALF_1P0 = 4'h2;
	localparam logic [3:0] DIV_HALF_1P5 = 4'h3;
	localparam logic [3:0] DIV_HALF_2P0 = 4'h4;
	localparam logic [3:0] DIV_HALF_3P0 = 4'h6;
	localparam logic [3:0] DIV_HALF_4P0 = 4'h8;
	localparam logic [3:0] DIV_HALF_NONE = 4'h0;

	typedef enum logic [1:0] {
		ACRB_FMT_LEFT_JUST = 2'h0,
		ACRB_FMT_I2S       = 2'h1,
		ACRB_FMT_TDM       = 2'h2,
		ACRB_FMT_RESERVED  = 2'h3
	} acrb_format_type;

	typedef enum logic [1:0] {
		ACRB_MODE_MASTER_SINGLE = 2'h0,
		ACRB_MODE_MASTER_DOUBLE = 2'h1,
		ACRB_MODE_MASTER_QUAD   = 2'h2,
		ACRB_MODE_SLAVE         = 2'h3
	} acrb_mode_type;
endpackage
`default_nettype wire

// ==== acrb_ovf_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface acrb_ovf_if #(parameter int CHANNELS = 8);
	logic [CHANNELS-1:0] event_hit;
	logic [CHANNELS-1:0] mask;
	logic [CHANNELS-1:0] flags;
	logic                read_clear;
	logic                pin_oe_b;

	modport keeper (input event_hit, input mask, input read_clear, output flags, output pin_oe_b);
	modport bank (output event_hit, output mask, output read_clear, input flags, input pin_oe_b);
endinterface
`default_nettype wire

// ==== acrb_ovf_flags.sv ====
`timescale 1ns/100ps
`default_nettype none
module acrb_ovf_flags #(
	parameter int CHANNELS = 8
) (
	input  wire logic  clk,      // core clock
	input  wire logic  rst_b,    // async reset, active low
	acrb_ovf_if.keeper ovf       // events in, flags and pin out
);
	logic [CHANNELS-1:0] flags;
	logic [CHANNELS-1:0] next_flags;
	logic                pin_oe_b;
	logic                next_pin_oe_b;

	always_comb
	begin
		next_flags = flags;
		if (ovf.read_clear)
			next_flags = '1; // see RULE4
		// an event in the clearing cycle still lands
		next_flags = next_flags & ~ovf.event_hit; // see RULE3
		next_pin_oe_b = ~|(~next_flags & ovf.mask); // see RULE5 see RULE6
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flags    <= CHANNELS'(acrb_pkg::RST_OVF_FLAGS);
			pin_oe_b <= 1'b1;
		end
		else
		begin
			flags    <= next_flags;
			pin_oe_b <= next_pin_oe_b;
		end
	end

	assign ovf.flags    = flags;
	assign ovf.pin_oe_b = pin_oe_b;

	property p_event_lands;
		@(posedge clk) disable iff (!rst_b)
		|ovf.event_hit |=> ((ovf.flags & $past(ovf.event_hit)) == '0);
	endproperty
	a_event_lands: assert property (p_event_lands) // see RULE3
		else $error("overflow event did not clear its flag");

	property p_sticky;
		@(posedge clk) disable iff (!rst_b)
		!ovf.read_clear |=> ((~ovf.flags & ~$past(ovf.flags)) == ~$past(ovf.flags));
	endproperty
	a_sticky: assert property (p_sticky) // see RULE4
		else $error("overflow flag released without a read");

	property p_read_releases;
		@(posedge clk) disable iff (!rst_b)
		(ovf.read_clear && ovf.event_hit == '0) |=> (ovf.flags == '1);
	endproperty
	a_read_releases: assert property (p_read_releases) // see RULE4
		else $error("status read did not release the flags");

	property p_pin_follows;
		@(posedge clk) disable iff (!rst_b)
		(ovf.event_hit & ovf.mask) != '0 |=> !ovf.pin_oe_b ##1 (!ovf.pin_oe_b || $past(ovf.read_clear));
	endproperty
	a_pin_follows: assert property (p_pin_follows) // see RULE5
		else $error("overflow pin not pulled after an unmasked event");

	property p_mask_gates;
		@(posedge clk) disable iff (!rst_b)
		((~ovf.flags & ovf.mask) == '0) |-> ovf.pin_oe_b;
	endproperty
	a_mask_gates: assert property (p_mask_gates) // see RULE6
		else $error("masked overflow flag drives the pin");

	c_event_in_clear: cover property (@(posedge clk) disable iff (!rst_b)
		ovf.read_clear && |ovf.event_hit);
endmodule // acrb_ovf_flags
`default_nettype wire

// ==== acrb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: format field picks left, I2S, TDM
// RULE2: range field picks master speed or slave
// RULE3: overflow drives channel status bit low
// RULE4: flags stay asserted until status read
// RULE5: unmasked asserted flag pulls overflow pin low
// RULE6: mask zero keeps flag off the pin
// RULE7: set filter bit disables channel DC filter
// RULE8: power-down bit 5 shuts down reference
// RULE9: bit 4 stops oscillator and master clock
// RULE10: pair bits gate clocks, zero pair data
// RULE11: mute bit zeroes that channel's samples
// RULE12: tristate bit floats its serial output
// RULE13: offsets 05h, 07h, 09h are reserved
// RULE14: pins rule until control port enable set
// RULE15: crystal divided by 1.5, 2, 4, products
// RULE16: reserved reads zero, writes ignored
module acrb_top #(
	parameter int         CHANNELS = 8,
	parameter logic [3:0] CHIP_ID  = 4'h5, // arbitrary value
	parameter logic [3:0] REVISION = 4'h0  // arbitrary value
) (
	input  wire logic                CORE_CLK_IN,       // core clock, 100 MHz
	input  wire logic                RST_B_IN,          // async reset, active low
	input  wire logic                REG_WR_IN,         // register write strobe
	input  wire logic                REG_RD_IN,         // register read strobe
	input  wire logic [7:0]          REG_ADDR_IN,       // register offset
	input  wire logic [7:0]          REG_WDATA_IN,      // write data
	output logic      [7:0]          REG_RDATA_OUT,     // read data, one cycle later
	input  wire logic [1:0]          SA_FORMAT_IN,      // stand-alone format pins
	input  wire logic [1:0]          SA_MODE_IN,        // stand-alone range pins
	input  wire logic [1:0]          SA_DIVIDER_IN,     // stand-alone crystal divider
	input  wire logic                SA_RATIO_IN,       // stand-alone clock ratio
	input  wire logic                CRYSTAL_IN,        // crystal input, sampled
	input  wire logic [CHANNELS-1:0] OVF_EVENT_IN,      // per-channel overflow pulse
	input  wire logic [3:0]          SER_DATA_IN,       // serial bits per output pin
	input  wire logic                SER_SLOT_IN,       // 0 odd channel, 1 even
	output logic      [1:0]          FORMAT_OUT,        // active audio format
	output logic      [1:0]          MODE_OUT,          // active speed range
	output logic                     CLOCK_MASTER_OUT,  // high when clock master
	output logic                     MCLK_TICK_OUT,     // divided crystal tick
	output logic      [CHANNELS-1:0] HPF_DISABLE_OUT,   // DC filter bypass
	output logic                     REF_SHUTDOWN_OUT,  // reference powered down
	output logic                     OSC_RUN_OUT,       // oscillator and clock pass
	output logic      [3:0]          PAIR_CLK_EN_OUT,   // clock enable per pair
	output logic      [3:0]          SERIAL_AUDIO_OUTPUT_OUT,         // serial audio outputs
	output logic      [3:0]          SERIAL_AUDIO_OUTPUT_OE_B_OUT,    // low while driving
	output logic                     OVF_PIN_OUT,       // open-drain level, always low
	output logic                     OVF_PIN_OE_B_OUT   // low while pulling the pin
);
	logic [7:0]          global;
	logic [7:0]          next_global;
	logic [7:0]          mask;
	logic [7:0]          next_mask;
	logic [7:0]          highpass_disable;
	logic [7:0]          next_hpf;
	logic [7:0]          power_down_control;
	logic [7:0]          next_pdn;
	logic [7:0]          mute;
	logic [7:0]          next_mute;
	logic [7:0]          tris;
	logic [7:0]          next_tris;
	logic [7:0]          rdata;
	logic [7:0]          next_rdata;
	logic [7:0]          pins;
	logic [7:0]          sync1;
	logic [7:0]          sync2;
	logic [7:0]          sync3;
	logic [7:0]          agree;
	logic [7:0]          pin_ok;
	logic [7:0]          next_pin_ok;
	logic [3:0]          half_cnt;
	logic [3:0]          next_half_cnt;
	logic [3:0]          half_ratio;
	logic                tick;
	logic                next_tick;
	logic                cry_edge;
	logic [7:0]          eff_global;
	logic [7:0]          eff_pdn;
	logic [7:0]          n_global;
	logic [7:0]          n_pdn;
	logic [7:0]          n_mute;
	logic [7:0]          n_tris;
	logic [3:0]          silence;
	acrb_pkg::acrb_format_type fmt;
	acrb_pkg::acrb_format_type next_fmt;
	acrb_pkg::acrb_mode_type   mode;
	acrb_pkg::acrb_mode_type   next_mode;
	logic [CHANNELS-1:0] hpf_out;
	logic [CHANNELS-1:0] next_hpf_out;
	logic                ref_pd;
	logic                next_ref_pd;
	logic                osc_run;
	logic                next_osc_run;
	logic [3:0]          pair_en;
	logic [3:0]          next_pair_en;
	logic [3:0]          serial_audio_output;
	logic [3:0]          next_serial_audio_output;
	logic [3:0]          serial_audio_output_oe_b;
	logic [3:0]          next_serial_audio_output_oe_b;

	acrb_ovf_if #(.CHANNELS(CHANNELS)) ovf_bus ();

	acrb_ovf_flags #(.CHANNELS(CHANNELS)) u_flags (
		.clk   (CORE_CLK_IN),
		.rst_b (RST_B_IN),
		.ovf   (ovf_bus.keeper)
	);

	// register writes and reads
	always_comb
	begin
		next_global = global;
		next_mask   = mask;
		next_hpf    = highpass_disable;
		next_pdn    = power_down_control;
		next_mute   = mute;
		next_tris   = tris;
		next_rdata  = rdata;
		if (REG_WR_IN)
		begin
			case (REG_ADDR_IN)
				acrb_pkg::ADDR_GLOBAL:   next_global = REG_WDATA_IN; // see RULE1 see RULE2
				acrb_pkg::ADDR_OVF_MASK: next_mask = REG_WDATA_IN; // see RULE6
				acrb_pkg::ADDR_HPF:      next_hpf = REG_WDATA_IN; // see RULE7
				acrb_pkg::ADDR_PDN:      next_pdn = REG_WDATA_IN & acrb_pkg::PDN_WRITE_MASK; // see RULE13
				acrb_pkg::ADDR_MUTE:     next_mute = REG_WDATA_IN; // see RULE11
				acrb_pkg::ADDR_TRIS:     next_tris = REG_WDATA_IN & acrb_pkg::TRIS_WRITE_MASK; // see RULE13
				default:                 next_global = global; // see RULE16
			endcase
		end
		if (REG_RD_IN)
		begin
			case (REG_ADDR_IN)
				acrb_pkg::ADDR_ID:        next_rdata = {CHIP_ID, REVISION};
				acrb_pkg::ADDR_GLOBAL:    next_rdata = global;
				acrb_pkg::ADDR_OVF_FLAGS: next_rdata = 8'(ovf_bus.flags); // see RULE4
				acrb_pkg::ADDR_OVF_MASK:  next_rdata = mask;
				acrb_pkg::ADDR_HPF:       next_rdata = highpass_disable;
				acrb_pkg::ADDR_PDN:       next_rdata = power_down_control;
				acrb_pkg::ADDR_MUTE:      next_rdata = mute;
				acrb_pkg::ADDR_TRIS:      next_rdata = tris;
				default:                  next_rdata = 8'h00; // see RULE13 see RULE16
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			global <= acrb_pkg::RST_GLOBAL;
			mask   <= acrb_pkg::RST_OVF_MASK;
			highpass_disable    <= acrb_pkg::RST_HPF;
			power_down_control    <= acrb_pkg::RST_PDN;
			mute   <= acrb_pkg::RST_MUTE;
			tris   <= acrb_pkg::RST_TRIS;
			rdata  <= acrb_pkg::RST_RDATA;
		end
		else
		begin
			global <= next_global;
			mask   <= next_mask;
			highpass_disable    <= next_hpf;
			power_down_control    <= next_pdn;
			mute   <= next_mute;
			tris   <= next_tris;
			rdata  <= next_rdata;
		end
	end

	// the clear rides on the read strobe; the value read is the one before it
	assign ovf_bus.read_clear = REG_RD_IN && (REG_ADDR_IN == acrb_pkg::ADDR_OVF_FLAGS); // see RULE4
	assign ovf_bus.event_hit  = OVF_EVENT_IN;
	assign ovf_bus.mask       = global[acrb_pkg::GLB_PORT_EN_BIT] ?
		CHANNELS'(mask) : CHANNELS'(acrb_pkg::RST_OVF_MASK); // see RULE6 see RULE14

	// pins from outside: three stages, a change counts once stages two and three agree
	assign pins  = {SA_RATIO_IN, SA_DIVIDER_IN, SA_MODE_IN, SA_FORMAT_IN, CRYSTAL_IN};
	assign agree = ~(sync2 ^ sync3);

	always_comb
	begin
		next_pin_ok = (pin_ok & ~agree) | (sync3 & agree);
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			sync1  <= 8'h00;
			sync2  <= 8'h00;
			sync3  <= 8'h00;
			pin_ok <= 8'h00;
		end
		else
		begin
			sync1  <= pins;
			sync2  <= sync1;
			sync3  <= sync2;
			pin_ok <= next_pin_ok;
		end
	end

	// global field as the pins give it until the control port takes over
	assign eff_global = global[acrb_pkg::GLB_PORT_EN_BIT] ? global :
		{1'b0, pin_ok[7:5], pin_ok[2:1], pin_ok[4:3]}; // see RULE14
	assign eff_pdn    = global[acrb_pkg::GLB_PORT_EN_BIT] ? power_down_control : acrb_pkg::RST_PDN;

	always_comb
	begin
		case (eff_global[acrb_pkg::GLB_RATIO_BIT:acrb_pkg::GLB_DIV_LSB])
			3'h0:      half_ratio = acrb_pkg::DIV_HALF_1P0;
			3'h4:      half_ratio = acrb_pkg::DIV_HALF_1P5;
			3'h1, 3'h2: half_ratio = acrb_pkg::DIV_HALF_2P0;
			3'h5, 3'h6: half_ratio = acrb_pkg::DIV_HALF_3P0;
			3'h3:      half_ratio = acrb_pkg::DIV_HALF_4P0;
			default:   half_ratio = acrb_pkg::DIV_HALF_NONE;
		endcase
	end

	// crystal sampled on the core clock: good for crystals below a quarter of it
	assign cry_edge = agree[0] && (sync3[0] != pin_ok[0]);

	always_comb
	begin
		next_half_cnt = half_cnt;
		next_tick     = 1'b0;
		if (eff_pdn[acrb_pkg::OSCILLATOR_SHUTDOWN_BIT] || half_ratio == acrb_pkg::DIV_HALF_NONE)
			next_half_cnt = acrb_pkg::RST_HALF_CNT; // see RULE9
		else if (cry_edge)
		begin
			if (half_cnt >= half_ratio - 4'h1)
			begin
				next_half_cnt = acrb_pkg::RST_HALF_CNT;
				next_tick     = 1'b1; // see RULE15
			end
			else
				next_half_cnt = half_cnt + 4'h1;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			half_cnt <= acrb_pkg::RST_HALF_CNT;
			tick     <= 1'b0;
		end
		else
		begin
			half_cnt <= next_half_cnt;
			tick     <= next_tick;
		end
	end

	// control outputs, taken from the next register values so they move with the write
	assign n_global = next_global[acrb_pkg::GLB_PORT_EN_BIT] ? next_global :
		{1'b0, next_pin_ok[7:5], next_pin_ok[2:1], next_pin_ok[4:3]}; // see RULE14
	assign n_pdn  = next_global[acrb_pkg::GLB_PORT_EN_BIT] ? next_pdn : acrb_pkg::RST_PDN;
	assign n_mute = next_global[acrb_pkg::GLB_PORT_EN_BIT] ? next_mute : acrb_pkg::RST_MUTE;
	assign n_tris = next_global[acrb_pkg::GLB_PORT_EN_BIT] ? next_tris : acrb_pkg::RST_TRIS;

	for (genvar p = 0; p < 4; p++)
	begin : g_pair
		assign silence[p] = ~next_pair_en[p] | n_mute[2*p + (SER_SLOT_IN ? 1 : 0)]; // see RULE10 see RULE11
	end

	always_comb
	begin
		next_fmt        = acrb_pkg::acrb_format_type'(n_global[acrb_pkg::GLB_FMT_LSB +: 2]); // see RULE1
		next_mode       = acrb_pkg::acrb_mode_type'(n_global[acrb_pkg::GLB_MODE_LSB +: 2]); // see RULE2
		next_hpf_out    = global[acrb_pkg::GLB_PORT_EN_BIT] || next_global[acrb_pkg::GLB_PORT_EN_BIT] ?
			CHANNELS'(next_global[acrb_pkg::GLB_PORT_EN_BIT] ? next_hpf : acrb_pkg::RST_HPF) :
			CHANNELS'(acrb_pkg::RST_HPF); // see RULE7
		next_ref_pd     = n_pdn[acrb_pkg::PDN_REF_BIT]; // see RULE8
		next_osc_run    = ~n_pdn[acrb_pkg::OSCILLATOR_SHUTDOWN_BIT]; // see RULE9
		next_pair_en    = ~n_pdn[acrb_pkg::PDN_PAIR_LSB +: 4] & {4{next_osc_run}}; // see RULE10
		next_serial_audio_output      = SER_DATA_IN & ~silence; // see RULE10 see RULE11
		next_serial_audio_output_oe_b = n_tris[3:0]; // see RULE12
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			fmt        <= acrb_pkg::ACRB_FMT_LEFT_JUST;
			mode       <= acrb_pkg::ACRB_MODE_MASTER_SINGLE;
			hpf_out    <= '0;
			ref_pd     <= 1'b0;
			osc_run    <= 1'b1;
			pair_en    <= 4'hF;
			serial_audio_output      <= 4'h0;
			serial_audio_output_oe_b <= 4'h0;
		end
		else
		begin
			fmt        <= next_fmt;
			mode       <= next_mode;
			hpf_out    <= next_hpf_out;
			ref_pd     <= next_ref_pd;
			osc_run    <= next_osc_run;
			pair_en    <= next_pair_en;
			serial_audio_output      <= next_serial_audio_output;
			serial_audio_output_oe_b <= next_serial_audio_output_oe_b;
		end
	end

	assign REG_RDATA_OUT    = rdata;
	assign FORMAT_OUT       = fmt;
	assign MODE_OUT         = mode;
	assign CLOCK_MASTER_OUT = (mode != acrb_pkg::ACRB_MODE_SLAVE); // see RULE2
	assign MCLK_TICK_OUT    = tick & osc_run; // see RULE9
	assign HPF_DISABLE_OUT  = hpf_out;
	assign REF_SHUTDOWN_OUT = ref_pd;
	assign OSC_RUN_OUT      = osc_run;
	assign PAIR_CLK_EN_OUT  = pair_en;
	assign SERIAL_AUDIO_OUTPUT_OUT        = serial_audio_output;
	assign SERIAL_AUDIO_OUTPUT_OE_B_OUT   = serial_audio_output_oe_b;
	assign OVF_PIN_OUT      = 1'b0;
	assign OVF_PIN_OE_B_OUT = ovf_bus.pin_oe_b; // see RULE5

	property p_format_write;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(REG_WR_IN && REG_ADDR_IN == acrb_pkg::ADDR_GLOBAL && REG_WDATA_IN[7])
			|=> (FORMAT_OUT == $past(REG_WDATA_IN[3:2])) && (MODE_OUT == $past(REG_WDATA_IN[1:0]));
	endproperty
	a_format_write: assert property (p_format_write) // see RULE1
		else $error("format or range not applied on control port write");

	property p_master;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(REG_WR_IN && REG_ADDR_IN == acrb_pkg::ADDR_GLOBAL && REG_WDATA_IN[7])
			|=> CLOCK_MASTER_OUT == ($past(REG_WDATA_IN[1:0]) != 2'h3);
	endproperty
	a_master: assert property (p_master) // see RULE2
		else $error("clock master flag disagrees with range");

	property p_pins_rule;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(!global[7] && !$past(global[7])) |-> (FORMAT_OUT == pin_ok[2:1]);
	endproperty
	a_pins_rule: assert property (p_pins_rule) // see RULE14
		else $error("format not taken from pins before control port enable");

	property p_ref;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(REG_WR_IN && REG_ADDR_IN == acrb_pkg::ADDR_PDN && global[7]) |=> REF_SHUTDOWN_OUT == $past(REG_WDATA_IN[5]);
	endproperty
	a_ref: assert property (p_ref) // see RULE8
		else $error("reference shutdown does not follow bit 5");

	property p_osc_stops;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		!OSC_RUN_OUT |-> (!MCLK_TICK_OUT && PAIR_CLK_EN_OUT == 4'h0);
	endproperty
	a_osc_stops: assert property (p_osc_stops) // see RULE9
		else $error("clock passes while oscillator is shut down");

	property p_silence;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		1'b1 |=> ((SERIAL_AUDIO_OUTPUT_OUT & $past(silence)) == 4'h0);
	endproperty
	a_silence: assert property (p_silence) // see RULE11
		else $error("muted or powered-down data reached the output");

	property p_pair_off;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(PAIR_CLK_EN_OUT != 4'hF) |-> ((SERIAL_AUDIO_OUTPUT_OUT & ~PAIR_CLK_EN_OUT) == 4'h0);
	endproperty
	a_pair_off: assert property (p_pair_off) // see RULE10
		else $error("powered-down pair still outputs data");

	property p_tristate;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(REG_WR_IN && REG_ADDR_IN == acrb_pkg::ADDR_TRIS && global[7]) |=> SERIAL_AUDIO_OUTPUT_OE_B_OUT == $past(REG_WDATA_IN[3:0]);
	endproperty
	a_tristate: assert property (p_tristate) // see RULE12
		else $error("serial output enable does not follow register");

	property p_reserved_read;
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		(REG_RD_IN && (REG_ADDR_IN == acrb_pkg::ADDR_RSVD_A || REG_ADDR_IN > acrb_pkg::ADDR_TRIS))
			|=> REG_RDATA_OUT == 8'h00;
	endproperty
	a_reserved_read: assert property (p_reserved_read) // see RULE16
		else $error("reserved register read nonzero");

	c_tick: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) MCLK_TICK_OUT);
	c_pin_low: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) !OVF_PIN_OE_B_OUT);
	c_flag_read: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		ovf_bus.read_clear ##1 REG_RDATA_OUT != 8'hFF);
endmodule // acrb_top
`default_nettype wire

// ==== acrb_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module acrb_host_model (
	input  wire logic       clk_in,   // core clock
	input  wire logic [7:0] rdata_in, // read data
	output var  logic       wr_out,   // write strobe
	output var  logic       rd_out,   // read strobe
	output var  logic [7:0] addr_out, // offset
	output var  logic [7:0] wdata_out // write data
);
	initial
	begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// released lines show the inverse so a stale value never passes
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(negedge clk_in);
		d = rdata_in;
	endtask
endmodule // acrb_host_model
`default_nettype wire

// ==== acrb_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module acrb_top_test;
	logic       clk;
	logic       rst_b;
	logic       wr;
	logic       rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [1:0] sa_fmt;
	logic [7:0] ovf;
	logic [3:0] ser;
	logic       slot;
	logic [1:0] fmt;
	logic [1:0] mode;
	logic       master;
	logic [7:0] highpass_disable;
	logic       ref_dn;
	logic       osc;
	logic [3:0] pair;
	logic [3:0] sdo;
	logic [3:0] sdo_oe_b;
	logic       pin;
	logic       pin_oe_b;
	logic [7:0] d;
	logic       xtal;
	logic       tick;
	int         num_errors;
	int         checks;
	acrb_host_model host (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
		.addr_out(addr), .wdata_out(wdata));
	acrb_top dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.SA_FORMAT_IN(sa_fmt), .SA_MODE_IN(2'h3), .SA_DIVIDER_IN(2'h0), .SA_RATIO_IN(1'b0),
		.CRYSTAL_IN(xtal), .OVF_EVENT_IN(ovf), .SER_DATA_IN(ser), .SER_SLOT_IN(slot),
		.FORMAT_OUT(fmt), .MODE_OUT(mode), .CLOCK_MASTER_OUT(master), .MCLK_TICK_OUT(tick),
		.HPF_DISABLE_OUT(highpass_disable), .REF_SHUTDOWN_OUT(ref_dn), .OSC_RUN_OUT(osc),
		.PAIR_CLK_EN_OUT(pair), .SERIAL_AUDIO_OUTPUT_OUT(sdo), .SERIAL_AUDIO_OUTPUT_OE_B_OUT(sdo_oe_b),
		.OVF_PIN_OUT(pin), .OVF_PIN_OE_B_OUT(pin_oe_b));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// crystal at an eighth of the core clock: four core cycles per half period
	initial
	begin
		xtal = 1'b0;
		forever
		begin
			repeat (4) @(posedge clk);
			xtal <= ~xtal;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic pulse(input logic [7:0] ch);
		@(posedge clk);
		ovf <= ch;
		@(posedge clk);
		ovf <= 8'h00;
		@(negedge clk);
	endtask
	task automatic t_reset();
		logic [15:0] tbl [11] = '{16'h02FF, 16'h03FF, 16'h0400, 16'h0500, 16'h0600, 16'h0700,
			16'h0800, 16'h0900, 16'h0A00, 16'h0B00, 16'h4000};
		check({6'h00, fmt}, 8'h01);
		check({7'h00, master}, 8'h00);
		foreach (tbl[i])
		begin
			host.get(tbl[i][15:8], d);
			check(d, tbl[i][7:0]);
		end
		$display("t_reset done");
	endtask
	task automatic t_global();
		for (int i = 0; i < 4; i++)
		begin
			host.put(8'h01, {4'h8, i[1:0], 2'h3 - i[1:0]});
			@(negedge clk);
			check({6'h00, fmt}, {6'h00, i[1:0]});
			check({6'h00, mode}, {6'h00, 2'h3 - i[1:0]});
			check({7'h00, master}, {7'h00, i != 0});
		end
		$display("t_global done");
	endtask
	task automatic t_ovf();
		pulse(8'h04);
		check({7'h00, pin_oe_b}, 8'h00);
		check({7'h00, pin}, 8'h00);
		host.get(8'h02, d);
		check(d, 8'hFB);
		check({7'h00, pin_oe_b}, 8'h01);
		host.get(8'h02, d);
		check(d, 8'hFF);
		host.put(8'h03, 8'hFB);
		pulse(8'h04);
		check({7'h00, pin_oe_b}, 8'h01);
		pulse(8'h80);
		check({7'h00, pin_oe_b}, 8'h00);
		host.get(8'h02, d);
		check(d, 8'h7B);
		host.get(8'h03, d);
		check(d, 8'hFB);
		$display("t_ovf done");
	endtask
	task automatic t_ctrl();
		host.put(8'h04, 8'hA5);
		host.put(8'h06, 8'hFF);
		@(negedge clk);
		check(highpass_disable, 8'hA5);
		check({5'h00, ref_dn, osc, 1'b0}, 8'h04);
		check({4'h0, pair}, 8'h00);
		host.get(8'h06, d);
		check(d, 8'h3F);
		host.put(8'h06, 8'h01);
		host.put(8'h08, 8'h04);
		@(posedge clk);
		ser <= 4'hF;
		slot <= 1'b0;
		@(posedge clk);
		slot <= 1'b1;
		@(negedge clk);
		check({4'h0, sdo}, 8'h0C);
		check({4'h0, pair}, 8'h0E);
		@(negedge clk);
		check({4'h0, sdo}, 8'h0E);
		host.put(8'h0A, 8'hF5);
		host.put(8'h05, 8'hFF);
		host.put(8'h07, 8'hFF);
		@(negedge clk);
		check({4'h0, sdo_oe_b}, 8'h05);
		host.get(8'h0A, d);
		check(d, 8'h05);
		host.get(8'h07, d);
		check(d, 8'h00);
		host.get(8'h04, d);
		check(d, 8'hA5);
		$display("t_ctrl done");
	endtask
	task automatic t_divider();
		logic [7:0] cfg [5] = '{8'h80, 8'hC0, 8'h90, 8'hD0, 8'hB0};
		logic [7:0] half [5] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08};
		int c;
		foreach (cfg[i])
		begin
			host.put(8'h01, cfg[i]);
			// the first tick may still count from the old ratio
			@(posedge tick);
			@(posedge tick);
			@(negedge clk);
			c = 0;
			do
			begin
				@(negedge clk);
				c++;
			end
			while (tick !== 1'b1 && c < 64);
			check(8'(c), half[i] * 8'h04);
		end
		$display("t_divider done");
	endtask
	initial
	begin
		rst_b = 1'b0;
		sa_fmt = 2'h1;
		ovf = 8'h00;
		ser = 4'h0;
		slot = 1'b0;
		num_errors = 0;
		checks = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		t_reset();
		t_global();
		t_ovf();
		t_ctrl();
		t_divider();
		complete_run();
	end
	// whole sequence needs under five hundred cycles
	initial
	begin
		#50000;
		num_errors++;
		complete_run();
	end
endmodule // acrb_top_test
`default_nettype wire
